/* File: rtl/ssm_safe_state.v */
// Notes on behaviour
// - Any trip enters reintegration state, stops drive and sets safe torque off in the same cycle; passivation or a same-cycle link error overrides the entry.
// - Reintegration accepted only after safe torque off done and no error.
// - Each function takes acknowledgement only from its configured source.
// - Reintegration ends only after every tripped function is acknowledged; a link error ends it in passivation, which on exit keeps only active trips.
// - Local request high if any tripped function may be acked locally.
// - Remote request high if any tripped function may be acked over link.
// - Only a rising edge of the remote ack bit acknowledges.
// - Auto-ack functions keep request flags low and acknowledge internally.
// - Reintegration goes operational once errors cleared and all acked.
// - Reintegration reports status 0,0,0, mode 01, safe flag 1.
// - Link CRC error or watchdog timeout enters module passivation.
// - Passivation stops drive, sets safe torque off, forces I/O to zero.
// - Passivation transmits fail-safe zero for all channels to the host.
// - While link broken in passivation, reconnect attempts repeat forever.
// - Module passivation is left only once the link error is resolved.
// - CRC flag is 1 in passivation caused by CRC error, else 0.
// - Timeout flag is 1 in passivation caused by watchdog timeout, else 0.
// - Passivation reports status 0,1,0, mode 01, requests 0, safe flag 1.
// - Operational reports status 0,0,0, mode 01, requests 0, safe flag 0.
// - Module fault is 1 only in fail-safe mode.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "ssm_map.vh"
module ssm_safe_state #(
    parameter NSF       = 8,
    parameter NCH       = 8,
    parameter RETRY_CYC = `SSM_RETRY_CYC
) (
    input  wire             CLK_SYS_I,
    input  wire             NRST_I,
    input  wire [NSF-1:0]   SF_VIOL_I,
    input  wire             STO_DONE_I,
    input  wire [NSF-1:0]   LOCAL_ACK_I,
    input  wire             REMOTE_ACK_BIT_I,
    input  wire             LINK_CRC_ERR_I,
    input  wire             LINK_WDT_I,
    input  wire             LINK_UP_I,
    input  wire             FAILSAFE_MODE_I,
    input  wire [NCH-1:0]   IO_VALUE_I,
    output reg  [NCH-1:0]   IO_OUT_O,
    output reg  [NCH-1:0]   TX_DATA_O,
    output reg              DRIVE_STOP_O,
    output reg              SAFE_TORQUE_OFF_O,
    output reg              LINK_RETRY_O,
    output reg              OPERATOR_ACK_REQUEST_O,
    output reg              FAILSAFE_VALUES_ACTIVE_O,
    output reg              MODULE_FAULT_O,
    output reg              CRC_ERR_FLAG_O,
    output reg              LINK_TIMEOUT_FLAG_O,
    output reg  [1:0]       MODULE_MODE_FIELD_O,
    output reg              LOCAL_ACK_REQUEST_O,
    output reg              REMOTE_ACK_REQUEST_O,
    output reg              SAFE_STATE_FLAG_O,
    input  wire [7:0]       S_AXI_AWADDR,
    input  wire             S_AXI_AWVALID,
    output wire             S_AXI_AWREADY,
    input  wire [31:0]      S_AXI_WDATA,
    input  wire [3:0]       S_AXI_WSTRB,
    input  wire             S_AXI_WVALID,
    output wire             S_AXI_WREADY,
    output reg  [1:0]       S_AXI_BRESP,
    output reg              S_AXI_BVALID,
    input  wire             S_AXI_BREADY,
    input  wire [7:0]       S_AXI_ARADDR,
    input  wire             S_AXI_ARVALID,
    output wire             S_AXI_ARREADY,
    output reg  [31:0]      S_AXI_RDATA,
    output reg  [1:0]       S_AXI_RRESP,
    output reg              S_AXI_RVALID,
    input  wire             S_AXI_RREADY
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam ST_OPER = 3'b001;
localparam ST_REIN = 3'b010;
localparam ST_PASV = 3'b100;

// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
// every input in raw_in passes two flops; only sync2_q is read
localparam NSYNC = 2 * NSF + 6;
wire [NSYNC-1:0] raw_in = {SF_VIOL_I, LOCAL_ACK_I, STO_DONE_I,
                           REMOTE_ACK_BIT_I, LINK_CRC_ERR_I, LINK_WDT_I,
                           LINK_UP_I, FAILSAFE_MODE_I};
reg  [NSYNC-1:0] sync1_q;
reg  [NSYNC-1:0] sync2_q;
always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
        sync1_q <= {NSYNC{1'b0}};
        sync2_q <= {NSYNC{1'b0}};
    end else begin
        sync1_q <= raw_in;
        sync2_q <= sync1_q;
    end
end
wire [NSF-1:0] viol      = sync2_q[NSYNC-1 -: NSF];
wire [NSF-1:0] lack      = sync2_q[NSF+5 -: NSF];
wire           sto_done  = sync2_q[5];
wire           rack      = sync2_q[4];
wire           crc_err   = sync2_q[3];
wire           wdt       = sync2_q[2];
wire           link_up   = sync2_q[1];
wire           fs_mode   = sync2_q[0];

// ----------------------------------------------------------------
// AXI4-Lite slave
// ----------------------------------------------------------------
reg  [NSF-1:0] src_q;
reg  [NSF-1:0] auto_q;
reg  [2:0]     state_q;
reg  [2:0]     state_d;
reg  [NSF-1:0] trip_q;
reg  [NSF-1:0] trip_d;
reg            crc_cause_q;
reg            crc_cause_d;
reg            wdt_cause_q;
reg            wdt_cause_d;
reg  [7:0]     awaddr_q;
reg            aw_have_q;
reg  [31:0]    wdata_q;
reg  [3:0]     wstrb_q;
reg            w_have_q;

assign S_AXI_AWREADY = !aw_have_q && !S_AXI_BVALID;
assign S_AXI_WREADY  = !w_have_q && !S_AXI_BVALID;
assign S_AXI_ARREADY = !S_AXI_RVALID;
wire   wr_go = aw_have_q && w_have_q && !S_AXI_BVALID;

wire [7:0] status_v = {3'h0, LINK_TIMEOUT_FLAG_O, CRC_ERR_FLAG_O,
                       MODULE_FAULT_O, FAILSAFE_VALUES_ACTIVE_O,
                       OPERATOR_ACK_REQUEST_O};
wire [7:0] profile_v = {3'h0, SAFE_STATE_FLAG_O, REMOTE_ACK_REQUEST_O,
                        LOCAL_ACK_REQUEST_O, MODULE_MODE_FIELD_O};

always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        awaddr_q     <= 8'h00;
        wdata_q      <= 32'h0000_0000;
        wstrb_q      <= 4'h0;
        S_AXI_BVALID <= 1'b0;
        S_AXI_BRESP  <= 2'b00;
        S_AXI_RVALID <= 1'b0;
        S_AXI_RRESP  <= 2'b00;
        S_AXI_RDATA  <= 32'h0000_0000;
        src_q        <= `SSM_RST_SRC;
        auto_q       <= `SSM_RST_AUTO;
    end else begin
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_q <= 1'b1;
            wdata_q  <= S_AXI_WDATA;
            wstrb_q  <= S_AXI_WSTRB;
        end
        if (wr_go) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= 2'b00;
            case (awaddr_q)
                `SSM_REG_CTRL: begin
                end
                `SSM_REG_SRC: begin
                    if (wstrb_q[0])
                        src_q <= wdata_q[NSF-1:0];
                end
                `SSM_REG_AUTO: begin
                    if (wstrb_q[0])
                        auto_q <= wdata_q[NSF-1:0];
                end
                default: S_AXI_BRESP <= 2'b10;
            endcase
        end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= 2'b00;
            case (S_AXI_ARADDR)
                `SSM_REG_CTRL:    S_AXI_RDATA <= 32'h0000_0000;
                `SSM_REG_SRC:     S_AXI_RDATA <= {24'h0, src_q};
                `SSM_REG_AUTO:    S_AXI_RDATA <= {24'h0, auto_q};
                `SSM_REG_STATUS:  S_AXI_RDATA <= {24'h0, status_v};
                `SSM_REG_PROFILE: S_AXI_RDATA <= {24'h0, profile_v};
                `SSM_REG_TRIP:    S_AXI_RDATA <= {24'h0, trip_q};
                default: begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= 2'b10;
                end
            endcase
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
end

// software local-ack pulse, one cycle per write of the ctrl bit
wire sw_lack = wr_go && (awaddr_q == `SSM_REG_CTRL) && wstrb_q[0] &&
               wdata_q[`SSM_CTRL_LACK];

// ----------------------------------------------------------------
// acknowledgement sources
// ----------------------------------------------------------------
reg  rack_q;
reg  [NSF-1:0] lack_q;
wire rack_rise = rack && !rack_q;
wire [NSF-1:0] lack_rise = lack & ~lack_q;
// src bit 1 means link, 0 means local inputs
// edges that arrive while ack_ok is low are dropped, not queued
wire ack_ok = sto_done && (viol == {NSF{1'b0}});
wire [NSF-1:0] acked = trip_q & (
      auto_q
    | (~auto_q & src_q  & {NSF{rack_rise}})
    | (~auto_q & ~src_q & (lack_rise | {NSF{sw_lack}}))) ;

// ----------------------------------------------------------------
// state machine
// ----------------------------------------------------------------
always @* begin
    state_d     = state_q;
    trip_d      = trip_q;
    crc_cause_d = crc_cause_q;
    wdt_cause_d = wdt_cause_q;
    case (state_q)
        ST_OPER: begin
            if (crc_err || wdt) begin
                state_d     = ST_PASV;
                crc_cause_d = crc_err;
                wdt_cause_d = wdt;
            end else if (viol != {NSF{1'b0}}) begin
                state_d = ST_REIN;
                trip_d  = viol;
            end
        end
        ST_REIN: begin
            if (crc_err || wdt) begin
                state_d     = ST_PASV;
                crc_cause_d = crc_err;
                wdt_cause_d = wdt;
            end else begin
                trip_d = trip_q | viol;
                if (ack_ok)
                    trip_d = trip_q & ~acked;
                if (ack_ok && trip_d == {NSF{1'b0}})
                    state_d = ST_OPER;
            end
        end
        ST_PASV: begin
            crc_cause_d = crc_cause_q | crc_err;
            wdt_cause_d = wdt_cause_q | wdt;
            if (!crc_err && !wdt && link_up) begin
                state_d     = (viol != {NSF{1'b0}}) ? ST_REIN : ST_OPER;
                trip_d      = viol;
                crc_cause_d = 1'b0;
                wdt_cause_d = 1'b0;
            end
        end
        // an illegal state code falls back to the safest state
        default: state_d = ST_PASV;
    endcase
end

// retry counter runs only while passivated with the link down
reg [31:0] retry_cnt_q;
always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
        state_q     <= ST_PASV;
        trip_q      <= {NSF{1'b0}};
        crc_cause_q <= 1'b0;
        wdt_cause_q <= 1'b0;
        rack_q      <= 1'b0;
        lack_q      <= {NSF{1'b0}};
        retry_cnt_q <= 32'h0000_0000;
    end else begin
        state_q     <= state_d;
        trip_q      <= trip_d;
        crc_cause_q <= crc_cause_d;
        wdt_cause_q <= wdt_cause_d;
        rack_q      <= rack;
        lack_q      <= lack;
        if (state_d == ST_PASV && !link_up) begin
            if (retry_cnt_q >= RETRY_CYC - 1)
                retry_cnt_q <= 32'h0000_0000;
            else
                retry_cnt_q <= retry_cnt_q + 32'h0000_0001;
        end else begin
            retry_cnt_q <= 32'h0000_0000;
        end
    end
end

// ----------------------------------------------------------------
// registered outputs, all but MODULE_FAULT_O, OPERATOR_ACK_REQUEST_O and MODULE_MODE_FIELD_O derived from the next state
// ----------------------------------------------------------------
// io values come from same-clock logic, so no synchroniser
wire pasv_d = (state_d == ST_PASV);
wire rein_d = (state_d == ST_REIN);
wire [NSF-1:0] pend_d = trip_d & ~auto_q;
always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
        IO_OUT_O                 <= {NCH{1'b0}};
        TX_DATA_O                <= {NCH{1'b0}};
        DRIVE_STOP_O             <= 1'b1;
        SAFE_TORQUE_OFF_O        <= 1'b1;
        LINK_RETRY_O             <= 1'b0;
        OPERATOR_ACK_REQUEST_O   <= 1'b0;
        FAILSAFE_VALUES_ACTIVE_O <= 1'b1;
        MODULE_FAULT_O           <= 1'b0;
        CRC_ERR_FLAG_O           <= 1'b0;
        LINK_TIMEOUT_FLAG_O      <= 1'b0;
        MODULE_MODE_FIELD_O      <= 2'b01;
        LOCAL_ACK_REQUEST_O      <= 1'b0;
        REMOTE_ACK_REQUEST_O     <= 1'b0;
        SAFE_STATE_FLAG_O        <= 1'b1;
    end else begin
        DRIVE_STOP_O         <= !state_d[0];
        SAFE_TORQUE_OFF_O    <= !state_d[0];
        IO_OUT_O             <= pasv_d ? {NCH{1'b0}} : IO_VALUE_I;
        TX_DATA_O            <= pasv_d ? {NCH{1'b0}} : IO_VALUE_I;
        LINK_RETRY_O         <= pasv_d && !link_up &&
                                (retry_cnt_q == 32'h0000_0000);
        OPERATOR_ACK_REQUEST_O   <= 1'b0;
        FAILSAFE_VALUES_ACTIVE_O <= pasv_d;
        MODULE_FAULT_O       <= fs_mode;
        CRC_ERR_FLAG_O       <= pasv_d && crc_cause_d;
        LINK_TIMEOUT_FLAG_O  <= pasv_d && wdt_cause_d;
        MODULE_MODE_FIELD_O  <= 2'b01;
        LOCAL_ACK_REQUEST_O  <= rein_d && |(pend_d & ~src_q);
        REMOTE_ACK_REQUEST_O <= rein_d && |(pend_d & src_q);
        SAFE_STATE_FLAG_O    <= !state_d[0];
    end
end

endmodule // ssm_safe_state

/* File: common/ssm_map.vh */
`ifndef SSM_MAP_VH
`define SSM_MAP_VH
// register byte offsets
`define SSM_REG_CTRL      8'h00
`define SSM_REG_SRC       8'h04
`define SSM_REG_AUTO      8'h08
`define SSM_REG_STATUS    8'h0c
`define SSM_REG_PROFILE   8'h10
`define SSM_REG_TRIP      8'h14
// ctrl field positions
`define SSM_CTRL_LACK     0
`define SSM_CTRL_CLR      1
// status field positions
`define SSM_ST_OAREQ      0
`define SSM_ST_FVACT      1
`define SSM_ST_FAULT      2
`define SSM_ST_CRC        3
`define SSM_ST_WDT        4
// profile field positions
`define SSM_PR_MODE0      0
`define SSM_PR_MODE1      1
`define SSM_PR_LREQ       2
`define SSM_PR_RREQ       3
`define SSM_PR_SAFE       4
// reset values
`define SSM_RST_SRC       8'h00
`define SSM_RST_AUTO      8'h00
// retry interval of the link reconnect pulse, in ns
`define SSM_RETRY_NS      1000
`define SSM_CLK_NS        25
`define SSM_RETRY_CYC     ((`SSM_RETRY_NS + `SSM_CLK_NS - 1) / `SSM_CLK_NS)
`endif

/* File: tb/ssm_safe_state_sva.sv */
`timescale 1ns/10ps
// ----------------------------------------
// state and status checks
// ----------------------------------------
module ssm_safe_state_sva #(
    parameter NSF = 8,
    parameter NCH = 8
) (
    input wire             CLK_SYS_I,
    input wire             NRST_I,
    input wire [NSF-1:0]   SF_VIOL_I,
    input wire             LINK_CRC_ERR_I,
    input wire             LINK_WDT_I,
    input wire             FAILSAFE_MODE_I,
    input wire [NCH-1:0]   IO_OUT_O,
    input wire [NCH-1:0]   TX_DATA_O,
    input wire             DRIVE_STOP_O,
    input wire             SAFE_TORQUE_OFF_O,
    input wire             LINK_RETRY_O,
    input wire             OPERATOR_ACK_REQUEST_O,
    input wire             FAILSAFE_VALUES_ACTIVE_O,
    input wire             MODULE_FAULT_O,
    input wire             CRC_ERR_FLAG_O,
    input wire             LINK_TIMEOUT_FLAG_O,
    input wire [1:0]       MODULE_MODE_FIELD_O,
    input wire             LOCAL_ACK_REQUEST_O,
    input wire             REMOTE_ACK_REQUEST_O,
    input wire             SAFE_STATE_FLAG_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!NRST_I);
    chk_io_forced: assert property (
        FAILSAFE_VALUES_ACTIVE_O |-> IO_OUT_O == '0 && TX_DATA_O == '0)
        else $error("channels not forced to zero");
    chk_viol_enters: assert property (
        |SF_VIOL_I |-> ##[1:4] SAFE_STATE_FLAG_O)
        else $error("violation did not enter safe state");
    chk_crc_cause: assert property (
        LINK_CRC_ERR_I |-> ##[1:4] (CRC_ERR_FLAG_O && FAILSAFE_VALUES_ACTIVE_O))
        else $error("crc error did not passivate");
    chk_wdt_cause: assert property (
        LINK_WDT_I |-> ##[1:4] (LINK_TIMEOUT_FLAG_O && FAILSAFE_VALUES_ACTIVE_O))
        else $error("timeout did not passivate");
    chk_cause_only: assert property (
        CRC_ERR_FLAG_O || LINK_TIMEOUT_FLAG_O |-> FAILSAFE_VALUES_ACTIVE_O)
        else $error("cause flag outside passivation");
    chk_safe_stop: assert property (
        SAFE_STATE_FLAG_O |-> DRIVE_STOP_O && SAFE_TORQUE_OFF_O)
        else $error("safe state without drive stop");
    chk_req_reint: assert property (
        LOCAL_ACK_REQUEST_O || REMOTE_ACK_REQUEST_O
        |-> SAFE_STATE_FLAG_O && !FAILSAFE_VALUES_ACTIVE_O)
        else $error("request flag outside reintegration");
    chk_oper_clean: assert property (
        !SAFE_STATE_FLAG_O |-> !FAILSAFE_VALUES_ACTIVE_O && !CRC_ERR_FLAG_O
        && !LINK_TIMEOUT_FLAG_O)
        else $error("operational status not clean");
    chk_report_const: assert property (
        !OPERATOR_ACK_REQUEST_O && MODULE_MODE_FIELD_O == 2'b01)
        else $error("mode field or ack request wrong");
    chk_fault_src: assert property (
        MODULE_FAULT_O |-> $past(FAILSAFE_MODE_I, 2)
        || $past(FAILSAFE_MODE_I, 3) || $past(FAILSAFE_MODE_I, 4))
        else $error("fault without fail-safe mode");
    chk_retry_pulse: assert property (
        LINK_RETRY_O |-> FAILSAFE_VALUES_ACTIVE_O ##1 !LINK_RETRY_O)
        else $error("retry pulse malformed");
endmodule // ssm_safe_state_sva
bind ssm_safe_state ssm_safe_state_sva #(.NSF(NSF), .NCH(NCH)) u_sva (.*);

/* File: tb/ssm_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// safety host: ack bit and received values
// ----------------------------------------
module ssm_host_model (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       ack_req_i,
    input  wire       ack_en_i,
    input  wire [7:0] tx_i,
    output reg        ack_bit_o,
    output reg  [7:0] rx_o
);
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_bit_o <= 1'b0;
            rx_o      <= 8'h00;
        end else begin
            // bit rises once per request while enabled, falls when request or enable drops
            ack_bit_o <= ack_en_i & ack_req_i;
            rx_o      <= tx_i;
        end
    end
endmodule // ssm_host_model

/* File: tb/ssm_safe_state_bench.sv */
`timescale 1ns/10ps
`include "ssm_map.vh"
module ssm_safe_state_bench;
    localparam RC = 4;
    logic        CLK_SYS_I, NRST_I, STO_DONE_I, LINK_CRC_ERR_I, LINK_WDT_I;
    logic        LINK_UP_I, FAILSAFE_MODE_I, host_en;
    logic [7:0]  SF_VIOL_I, LOCAL_ACK_I, IO_VALUE_I, S_AXI_AWADDR;
    logic [7:0]  S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, rnd, rv;
    logic [3:0]  S_AXI_WSTRB;
    logic [1:0]  rr;
    logic        S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
    logic        S_AXI_ARVALID, S_AXI_RREADY;
    wire  [7:0]  IO_OUT_O, TX_DATA_O, host_rx;
    wire         REMOTE_ACK_BIT_I, DRIVE_STOP_O, SAFE_TORQUE_OFF_O;
    wire         LINK_RETRY_O, OPERATOR_ACK_REQUEST_O, MODULE_FAULT_O;
    wire         FAILSAFE_VALUES_ACTIVE_O, CRC_ERR_FLAG_O, SAFE_STATE_FLAG_O;
    wire         LINK_TIMEOUT_FLAG_O, LOCAL_ACK_REQUEST_O, REMOTE_ACK_REQUEST_O;
    wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
    wire         S_AXI_ARREADY, S_AXI_RVALID;
    wire  [1:0]  MODULE_MODE_FIELD_O, S_AXI_BRESP, S_AXI_RRESP;
    wire  [31:0] S_AXI_RDATA;
    int          n_mismatch, samples_checked, cyc, k, j, np;

    ssm_safe_state #(.RETRY_CYC(RC)) uut (.*);
    ssm_host_model h (.clk_i(CLK_SYS_I), .nrst_i(NRST_I),
        .ack_req_i(REMOTE_ACK_REQUEST_O), .ack_en_i(host_en),
        .tx_i(TX_DATA_O), .ack_bit_o(REMOTE_ACK_BIT_I), .rx_o(host_rx));

    always #12.5 CLK_SYS_I = ~CLK_SYS_I;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function logic [31:0] lfsr(input logic [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function logic [7:0] exp_io(input logic pas, input logic [7:0] v);
        exp_io = pas ? 8'h00 : v;
    endfunction
    task results;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge CLK_SYS_I);
    endtask
    task lack(input int f);
        @(posedge CLK_SYS_I);
        LOCAL_ACK_I <= 8'h01 << f;
        tick(3);
        LOCAL_ACK_I <= 8'h00;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge CLK_SYS_I);
        S_AXI_AWADDR  <= a;
        S_AXI_WDATA   <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID  <= 1'b1;
        S_AXI_BREADY  <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge CLK_SYS_I);
            ta = ta | S_AXI_AWREADY;
            tw = tw | S_AXI_WREADY;
            if (ta) S_AXI_AWVALID <= 1'b0;
            if (tw) S_AXI_WVALID <= 1'b0;
        end
        do @(posedge CLK_SYS_I); while (S_AXI_BVALID !== 1'b1);
        rr = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge CLK_SYS_I);
        S_AXI_ARADDR  <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY  <= 1'b1;
        do @(posedge CLK_SYS_I); while (S_AXI_ARREADY !== 1'b1);
        S_AXI_ARVALID <= 1'b0;
        do @(posedge CLK_SYS_I); while (S_AXI_RVALID !== 1'b1);
        rv = S_AXI_RDATA;
        rr = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask
    always @(posedge CLK_SYS_I) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            results;
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {CLK_SYS_I, NRST_I, STO_DONE_I, LINK_CRC_ERR_I, LINK_WDT_I} = '0;
        {FAILSAFE_MODE_I, host_en, S_AXI_AWVALID, S_AXI_WVALID} = '0;
        {S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, SF_VIOL_I} = '0;
        {LOCAL_ACK_I, IO_VALUE_I, S_AXI_AWADDR, S_AXI_ARADDR} = '0;
        {S_AXI_WDATA, n_mismatch, samples_checked, cyc} = '0;
        S_AXI_WSTRB = 4'hf;
        LINK_UP_I = 1'b1;
        rnd = 32'h4876;
        tick(8);
        NRST_I <= 1'b1;
        rnd = lfsr(rnd);
        IO_VALUE_I <= rnd[7:0] | 8'h01;
        rd(`SSM_REG_SRC);
        chk(rv, `SSM_RST_SRC);
        rd(`SSM_REG_AUTO);
        chk(rv, `SSM_RST_AUTO);
        rd(8'h3c);
        chk(rr, 2'b10);
        tick(4);
        chk(SAFE_STATE_FLAG_O, 0);
        chk(IO_OUT_O, exp_io(0, IO_VALUE_I));
        rnd = lfsr(rnd);
        k = rnd[2:0];
        j = (k + 1) % 8;
        SF_VIOL_I <= 8'h01 << k;
        tick(5);
        chk({SAFE_STATE_FLAG_O, SAFE_TORQUE_OFF_O}, 2'b11);
        chk(FAILSAFE_VALUES_ACTIVE_O, 0);
        lack(k);
        tick(4);
        chk(SAFE_STATE_FLAG_O, 1);
        SF_VIOL_I <= 8'h00;
        STO_DONE_I <= 1'b1;
        tick(5);
        chk({LOCAL_ACK_REQUEST_O, REMOTE_ACK_REQUEST_O}, 2'b10);
        rd(`SSM_REG_TRIP);
        chk(rv[7:0], 8'h01 << k);
        lack(k);
        tick(5);
        chk(SAFE_STATE_FLAG_O, 0);
        STO_DONE_I <= 1'b0;
        wr(`SSM_REG_SRC, 32'h1 << j);
        SF_VIOL_I <= (8'h01 << k) | (8'h01 << j);
        tick(5);
        SF_VIOL_I <= 8'h00;
        STO_DONE_I <= 1'b1;
        tick(5);
        chk({LOCAL_ACK_REQUEST_O, REMOTE_ACK_REQUEST_O}, 2'b11);
        lack(j);
        tick(4);
        rd(`SSM_REG_TRIP);
        chk(rv[7:0], (8'h01 << k) | (8'h01 << j));
        host_en <= 1'b1;
        tick(6);
        rd(`SSM_REG_TRIP);
        chk(rv[7:0], 8'h01 << k);
        chk({SAFE_STATE_FLAG_O, REMOTE_ACK_REQUEST_O}, 2'b10);
        wr(`SSM_REG_CTRL, 32'h1 << `SSM_CTRL_LACK);
        tick(5);
        chk(SAFE_STATE_FLAG_O, 0);
        host_en <= 1'b0;
        STO_DONE_I <= 1'b0;
        wr(`SSM_REG_SRC, 32'h0);
        wr(`SSM_REG_AUTO, 32'h1 << k);
        SF_VIOL_I <= 8'h01 << k;
        tick(5);
        chk({SAFE_STATE_FLAG_O, LOCAL_ACK_REQUEST_O}, 2'b10);
        SF_VIOL_I <= 8'h00;
        STO_DONE_I <= 1'b1;
        tick(6);
        chk(SAFE_STATE_FLAG_O, 0);
        STO_DONE_I <= 1'b0;
        wr(`SSM_REG_AUTO, 32'h0);
        chk(rr, 2'b00);
        wr(8'h3c, 32'h0);
        chk(rr, 2'b10);
        LINK_CRC_ERR_I <= 1'b1;
        tick(5);
        chk({FAILSAFE_VALUES_ACTIVE_O, CRC_ERR_FLAG_O,
             LINK_TIMEOUT_FLAG_O, SAFE_STATE_FLAG_O}, 4'b1101);
        chk(IO_OUT_O, exp_io(1, IO_VALUE_I));
        chk(host_rx, 8'h00);
        LINK_CRC_ERR_I <= 1'b0;
        tick(5);
        chk(FAILSAFE_VALUES_ACTIVE_O, 0);
        LINK_WDT_I <= 1'b1;
        LINK_UP_I <= 1'b0;
        tick(4);
        np = 0;
        repeat (8 * RC) begin
            @(posedge CLK_SYS_I);
            if (LINK_RETRY_O === 1'b1) np++;
        end
        chk(np, 8);
        chk({CRC_ERR_FLAG_O, LINK_TIMEOUT_FLAG_O}, 2'b01);
        LINK_WDT_I <= 1'b0;
        tick(6);
        chk(FAILSAFE_VALUES_ACTIVE_O, 1);
        LINK_UP_I <= 1'b1;
        tick(6);
        chk(FAILSAFE_VALUES_ACTIVE_O, 0);
        FAILSAFE_MODE_I <= 1'b1;
        tick(5);
        chk(MODULE_FAULT_O, 1);
        FAILSAFE_MODE_I <= 1'b0;
        tick(5);
        chk(MODULE_FAULT_O, 0);
        wr(`SSM_REG_SRC, 32'hff);
        NRST_I <= 1'b0;
        tick(2);
        chk({SAFE_STATE_FLAG_O, FAILSAFE_VALUES_ACTIVE_O}, 2'b11);
        NRST_I <= 1'b1;
        tick(5);
        chk({SAFE_STATE_FLAG_O, FAILSAFE_VALUES_ACTIVE_O}, 2'b00);
        rd(`SSM_REG_SRC);
        chk(rv, `SSM_RST_SRC);
        results;
    end
endmodule // ssm_safe_state_bench
